// ===== dic_classify.sv
// Instruction classifier: target unit and register usage of one 32-bit word
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.svh"

module dic_classify (
    // Instruction word
    input wire logic [`DIC_INSTR_W-1:0] instr,
    // Classification
    output dic_pkg::dic_unit_e unit,
    output dic_pkg::dic_reg_t src_a,
    output dic_pkg::dic_reg_t src_b,
    output dic_pkg::dic_reg_t dst,
    output logic use_a,
    output logic use_b,
    output logic has_dst
);
    import dic_pkg::*;

    wire [5:0] opc = instr[`DIC_OP_HI:`DIC_OP_LO];
    wire [4:0] ra = instr[`DIC_RA_HI:`DIC_RA_LO];
    wire [4:0] rb = instr[`DIC_RB_HI:`DIC_RB_LO];
    wire [4:0] rc = instr[`DIC_RC_HI:`DIC_RC_LO];
    wire is_mem = (opc[5:3] == `DIC_OP_MEMI) || (opc[5:3] == `DIC_OP_MEMF) || (opc[5:3] == `DIC_OP_MEMQ);
    wire is_store = is_mem && opc[2];
    wire mem_fp = (opc[5:3] == `DIC_OP_MEMF);
    wire is_br = (opc[5:3] == `DIC_OP_BRA) || (opc[5:3] == `DIC_OP_BRB);
    wire is_jump = (opc == `DIC_OP_JUMP);
    wire is_fpop = (opc[5:2] == `DIC_OP_FPOP);
    wire is_intop = (opc[5:2] == `DIC_OP_INTA) || (opc == `DIC_OP_INTB);
    // Unconditional branches write a link register, conditional ones test ra
    wire br_link = is_br && !opc[3];

    assign unit = (is_br || is_jump) ? DIC_UNIT_BR :
                  is_mem ? DIC_UNIT_LSU :
                  is_fpop ? DIC_UNIT_FPU : DIC_UNIT_INT;
    assign src_a = {is_fpop || mem_fp, ra};
    assign src_b = {is_fpop, rb};
    assign dst = (is_fpop || is_intop) ? {is_fpop, rc} : {mem_fp, ra};
    assign use_a = is_fpop || is_intop || is_store || (is_br && opc[3]);
    assign use_b = is_fpop || is_intop || is_mem || is_jump;
    assign has_dst = is_fpop || is_intop || (is_mem && !is_store) || br_link || is_jump;
endmodule // dic_classify
`default_nettype wire

// ===== dic_defs.svh
// Constants for the dual-issue control block
`ifndef DIC_DEFS_SVH
`define DIC_DEFS_SVH

`define DIC_INSTR_W 32
`define DIC_PAIR_W 64
`define DIC_QUAD_BYTES 8
`define DIC_SLOT_BIT 2
`define DIC_NUM_UNITS 4
`define DIC_NUM_WB 4
`define DIC_REG_IDX_W 6
`define DIC_ZERO_REG 5'h1F
`define DIC_OP_HI 31
`define DIC_OP_LO 26
`define DIC_RA_HI 25
`define DIC_RA_LO 21
`define DIC_RB_HI 20
`define DIC_RB_LO 16
`define DIC_RC_HI 4
`define DIC_RC_LO 0
`define DIC_OP_MEMI 3'h1
`define DIC_OP_MEMF 3'h4
`define DIC_OP_MEMQ 3'h5
`define DIC_OP_BRA 3'h6
`define DIC_OP_BRB 3'h7
`define DIC_OP_FPOP 4'h5
`define DIC_OP_INTA 4'h4
`define DIC_OP_INTB 6'h1C
`define DIC_OP_JUMP 6'h1A

`endif

// ===== dic_issue_control.sv
// Dual-issue control: decodes an aligned instruction pair and dispatches to four units
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.svh"

module dic_issue_control #(
    parameter int NUM_WB = `DIC_NUM_WB
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Quadword from the fetcher; pc_slot high means entry at the second slot
    input wire logic pair_valid,
    input wire logic [`DIC_PAIR_W-1:0] pair_data,
    input wire logic pair_pc_slot,
    output logic pair_ready,
    // Unit readiness, order: integer, load/store, floating-point, branch
    input wire logic [`DIC_NUM_UNITS-1:0] unit_ready,
    // Dispatch to the units, same order
    output logic [`DIC_NUM_UNITS-1:0] unit_valid,
    output logic [`DIC_NUM_UNITS-1:0][`DIC_INSTR_W-1:0] unit_instr,
    // Register write-back ports clearing pending writes
    input wire logic [NUM_WB-1:0] wb_valid,
    input wire logic [NUM_WB-1:0][`DIC_REG_IDX_W-1:0] wb_reg
);
    import dic_pkg::*;

    localparam int NREGS = 1 << `DIC_REG_IDX_W;

    // Pending-write test; register 31 of each file is the zero register
    function automatic logic reg_busy(input logic [NREGS-1:0] pend, input dic_reg_t r);
        reg_busy = pend[r] && (r[4:0] != `DIC_ZERO_REG);
    endfunction

    function automatic logic same_reg(input dic_reg_t x, input dic_reg_t y);
        same_reg = (x == y) && (x[4:0] != `DIC_ZERO_REG);
    endfunction

    // Dispatch decode, shared by both slots
    function automatic logic unit_match(input dic_unit_e slot_u, input int u);
        unit_match = (slot_u == dic_unit_e'(u[1:0]));
    endfunction

    dic_state_e state;
    dic_state_e next_state;
    logic buf_valid;
    logic [`DIC_PAIR_W-1:0] buf_data;
    logic buf_start;
    logic [NREGS-1:0] pending;
    logic [NREGS-1:0] next_pending;

    // Decode of both slots
    dic_unit_e slot_unit [2];
    dic_reg_t slot_a [2];
    dic_reg_t slot_b [2];
    dic_reg_t slot_d [2];
    logic slot_use_a [2];
    logic slot_use_b [2];
    logic slot_has_d [2];
    logic slot_free [2];

    for (genvar s = 0; s < 2; s++) begin : g_slot
        dic_classify u_classify (
            .instr(buf_data[s*`DIC_INSTR_W +: `DIC_INSTR_W]),
            .unit(slot_unit[s]),
            .src_a(slot_a[s]),
            .src_b(slot_b[s]),
            .dst(slot_d[s]),
            .use_a(slot_use_a[s]),
            .use_b(slot_use_b[s]),
            .has_dst(slot_has_d[s])
        );
        // One wire per cause, so a stalled slot shows why it waits
        wire unit_ok = unit_ready[slot_unit[s]];
        wire a_busy = slot_use_a[s] && reg_busy(pending, slot_a[s]);
        wire b_busy = slot_use_b[s] && reg_busy(pending, slot_b[s]);
        wire d_busy = slot_has_d[s] && reg_busy(pending, slot_d[s]);
        assign slot_free[s] = unit_ok && !a_busy && !b_busy && !d_busy;
    end

    // Second slot may join the first only with a distinct unit and no dependency inside the pair
    wire raw_a = slot_use_a[1] && same_reg(slot_d[0], slot_a[1]);
    wire raw_b = slot_use_b[1] && same_reg(slot_d[0], slot_b[1]);
    wire waw = slot_has_d[1] && same_reg(slot_d[0], slot_d[1]);
    wire pair_dep = slot_has_d[0] && (raw_a || raw_b || waw);
    wire unit_clash = (slot_unit[0] == slot_unit[1]);

    // A pair is attempted only when the quadword was entered at its first slot
    wire first_phase = buf_valid && (state == DIC_ST_PAIR) && !buf_start;
    wire second_only = buf_valid && ((state == DIC_ST_SECOND) || buf_start);
    wire issue_first = first_phase && slot_free[0];
    wire issue_dual = issue_first && slot_free[1] && !unit_clash && !pair_dep;
    // Second slot never overtakes a stalled first slot
    wire issue_second = issue_dual || (second_only && slot_free[1]);
    wire first_alone = issue_first && !issue_dual;
    wire consume = issue_second;
    wire load_buf = pair_valid && pair_ready;
    wire next_buf_valid = load_buf || (buf_valid && !consume);

    always_comb begin
        next_state = state;
        case (state)
            DIC_ST_PAIR: begin
                // Entry at the second slot issues it from this state and stays here
                if (first_alone) begin
                    next_state = DIC_ST_SECOND;
                end
            end
            DIC_ST_SECOND: begin
                // Only the leftover second slot may leave; nothing new is pulled in
                if (consume) begin
                    next_state = DIC_ST_PAIR;
                end
            end
        endcase
    end

    // Issue sets the pending bit; it wins over a write-back in the same cycle
    always_comb begin
        next_pending = pending;
        for (int w = 0; w < NUM_WB; w++) begin
            if (wb_valid[w]) begin
                next_pending[wb_reg[w]] = 1'b0;
            end
        end
        if (issue_first && slot_has_d[0]) begin
            next_pending[slot_d[0]] = 1'b1;
        end
        if (issue_second && slot_has_d[1]) begin
            next_pending[slot_d[1]] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= DIC_ST_PAIR;
            buf_valid <= 1'b0;
            buf_data <= 64'h0;
            buf_start <= 1'b0;
            pending <= '0;
            pair_ready <= 1'b0;
        end else begin
            state <= next_state;
            buf_valid <= next_buf_valid;
            pending <= next_pending;
            // Costs a bubble between quadwords but keeps pair_ready a flop
            pair_ready <= !next_buf_valid;
            if (load_buf) begin
                buf_data <= pair_data;
                buf_start <= pair_pc_slot;
            end
        end
    end

    // One dispatch register per unit; the clash check guarantees one writer
    for (genvar u = 0; u < `DIC_NUM_UNITS; u++) begin : g_unit
        wire hit0 = issue_first && unit_match(slot_unit[0], u);
        wire hit1 = issue_second && unit_match(slot_unit[1], u);
        // Slot 0 wins a tie, which a legal pair never produces
        wire [`DIC_INSTR_W-1:0] next_instr = hit0 ? buf_data[`DIC_INSTR_W-1:0]
            : buf_data[`DIC_PAIR_W-1:`DIC_INSTR_W];
        always_ff @(posedge clock) begin
            if (rst) begin
                unit_valid[u] <= 1'b0;
                unit_instr[u] <= 32'h0;
            end else begin
                unit_valid[u] <= hit0 || hit1;
                if (hit0 || hit1) begin
                    unit_instr[u] <= next_instr;
                end
            end
        end
    end
endmodule // dic_issue_control
`default_nettype wire

// ===== dic_issue_control_chk.sv
// Port checker for the dual-issue control block
`timescale 1ns/1ps
`default_nettype none
module dic_issue_control_chk #(
    parameter int NUM_WB = 4
) (
    // Watched ports of the issue control
    input wire logic clock,
    input wire logic rst,
    input wire logic pair_valid,
    input wire logic [63:0] pair_data,
    input wire logic pair_pc_slot,
    input wire logic pair_ready,
    input wire logic [3:0] unit_ready,
    input wire logic [3:0] unit_valid,
    input wire logic [3:0][31:0] unit_instr,
    input wire logic [NUM_WB-1:0] wb_valid,
    input wire logic [NUM_WB-1:0][5:0] wb_reg
);
    logic [63:0] held;
    logic [31:0] sel_x;
    wire logic take = pair_valid && pair_ready;
    always_ff @(posedge clock) if (take) held <= pair_data;
    // XOR of dispatched words lets one compare cover any pair of units
    always_comb begin
        sel_x = '0;
        for (int i = 0; i < 4; i++) if (unit_valid[i]) sel_x ^= unit_instr[i];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    take_drop_a: assert property (take |=> !pair_ready) else $error("ready high after take");
    no_early_a: assert property (take |=> unit_valid == 4'h0) else $error("dispatch before decode");
    ready_gate_a: assert property (unit_valid != 4'h0 |-> (unit_valid & ~$past(unit_ready)) == 4'h0)
        else $error("dispatch to busy unit");
    two_max_a: assert property ($countones(unit_valid) <= 2) else $error("over two dispatches");
    free_after_a: assert property ($rose(pair_ready) && !$past(rst) && !$past(rst, 2) |-> unit_valid != 4'h0)
        else $error("ready without issue");
    slot_entry_a: assert property (take && pair_pc_slot |=> ##1 $countones(unit_valid) <= 1)
        else $error("pair from second slot");
    pair_words_a: assert property ($countones(unit_valid) == 2 |-> sel_x == (held[31:0] ^ held[63:32]))
        else $error("pair not from one quadword");
    one_word_a: assert property ($countones(unit_valid) == 1 |-> sel_x == held[31:0] || sel_x == held[63:32])
        else $error("single issue of foreign word");
endmodule // dic_issue_control_chk
bind dic_issue_control dic_issue_control_chk #(.NUM_WB(NUM_WB)) dic_issue_control_chk_i (.clock(clock), .rst(rst),
    .pair_valid(pair_valid), .pair_data(pair_data), .pair_pc_slot(pair_pc_slot), .pair_ready(pair_ready),
    .unit_ready(unit_ready), .unit_valid(unit_valid), .unit_instr(unit_instr), .wb_valid(wb_valid), .wb_reg(wb_reg));
`default_nettype wire

// ===== dic_issue_control_test.sv
// Self-checking bench for the dual-issue control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dic_issue_control_test;
    localparam logic [31:0] w_int = 32'h0022_0003, w_int2 = 32'h0085_0006, w_br = 32'hE3E0_0000, w_jmp = 32'h6BFF_0000;
    localparam logic [31:0] w_fp = 32'h5BFF_0003, w_st = 32'h33FF_0000, w_ld = 32'h203F_0000, w_iop = 32'h403F_0002;
    logic clock, rst, pair_valid, pair_pc_slot, pair_ready;
    logic [63:0] pair_data;
    logic [3:0] stall, unit_ready, unit_valid, taken, wb_valid;
    logic [3:0][31:0] unit_instr;
    logic [3:0][5:0] wb_reg;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    dic_issue_control dic_issue_control_i (.clock(clock), .rst(rst), .pair_valid(pair_valid), .pair_data(pair_data),
        .pair_pc_slot(pair_pc_slot), .pair_ready(pair_ready), .unit_ready(unit_ready), .unit_valid(unit_valid),
        .unit_instr(unit_instr), .wb_valid(wb_valid), .wb_reg(wb_reg));
    dic_unit_model dic_unit_model_i (.clock(clock), .stall(stall), .unit_valid(unit_valid), .unit_ready(unit_ready),
        .taken(taken));
    task automatic offer(logic [31:0] hi, logic [31:0] lo, logic slot);
        int n = 0;
        pair_data = {hi, lo};
        pair_pc_slot = slot;
        pair_valid = 1'b1;
        while (pair_ready !== 1'b1 && n < 20) begin
            @(posedge clock) #1;
            n++;
        end
        `CHK(pair_ready, 1'b1)
        @(posedge clock) #1;
        pair_valid = 1'b0;
        `CHK(pair_ready, 1'b0)
    endtask
    task automatic nxt(logic [3:0] exp);
        @(posedge clock) #1;
        `CHK(taken, exp)
    endtask
    task automatic dual_issue();
        offer(w_br, w_int, 1'b0);
        nxt(4'h9);
        `CHK(unit_instr[3], w_br)
        offer(w_fp, w_st, 1'b0);
        nxt(4'h6);
        `CHK(unit_instr[1], w_st)
        `CHK(unit_instr[2], w_fp)
    endtask
    task automatic split_same();
        offer(w_int2, w_int, 1'b0);
        nxt(4'h1);
        `CHK(unit_instr[0], w_int)
        nxt(4'h1);
        `CHK(unit_instr[0], w_int2)
    endtask
    // Second slot's unit busy: first goes alone, second waits; the jump also writes the zero register
    task automatic busy_second();
        stall = 4'h8;
        offer(w_jmp, w_int, 1'b0);
        nxt(4'h1);
        nxt(4'h0);
        `CHK(pair_ready, 1'b0)
        stall = 4'h0;
        nxt(4'h8);
        `CHK(unit_instr[3], w_jmp)
    endtask
    task automatic hold_order();
        stall = 4'h1;
        offer(w_br, w_int, 1'b0);
        nxt(4'h0);
        nxt(4'h0);
        stall = 4'h0;
        nxt(4'h9);
        `CHK(unit_instr[0], w_int)
    endtask
    task automatic reg_wait();
        offer(w_br, w_int, 1'b1);
        nxt(4'h8);
        offer(w_iop, w_ld, 1'b0);
        nxt(4'h2);
        `CHK(unit_instr[1], w_ld)
        nxt(4'h0);
        wb_valid = 4'h1;
        wb_reg[0] = 6'h01;
        nxt(4'h0);
        wb_valid = 4'h0;
        nxt(4'h1);
        `CHK(unit_instr[0], w_iop)
    endtask
    // Reset with a pair loaded: nothing may be dispatched and the buffer empties
    task automatic mid_reset();
        offer(w_br, w_int, 1'b0);
        rst = 1'b1;
        @(posedge clock) #1;
        `CHK(pair_ready, 1'b0)
        `CHK(unit_valid, 4'h0)
        `CHK(unit_instr[3], 32'h0)
        rst = 1'b0;
        nxt(4'h0);
        `CHK(pair_ready, 1'b1)
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 500) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        {pair_valid, pair_pc_slot, pair_data, stall, wb_valid, wb_reg} = '0;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        dual_issue();
        split_same();
        busy_second();
        hold_order();
        reg_wait();
        mid_reset();
        print_verdict();
    end
endmodule // dic_issue_control_test
`default_nettype wire

// ===== dic_pkg.sv
// Types shared by the dual-issue control block
package dic_pkg;
    typedef enum logic [1:0] {
        DIC_UNIT_INT = 2'h0,
        DIC_UNIT_LSU = 2'h1,
        DIC_UNIT_FPU = 2'h2,
        DIC_UNIT_BR = 2'h3
    } dic_unit_e;

    // Gray path: pair -> second -> pair
    typedef enum logic {
        DIC_ST_PAIR = 1'b0,
        DIC_ST_SECOND = 1'b1
    } dic_state_e;

    typedef logic [5:0] dic_reg_t;
endpackage

// ===== dic_unit_model.sv
// Behavioural model of the four execution units
`timescale 1ns/1ps
`default_nettype none
module dic_unit_model (
    // Order: integer, load/store, floating-point, branch
    input wire logic clock,
    input wire logic [3:0] stall,
    input wire logic [3:0] unit_valid,
    output logic [3:0] unit_ready,
    output logic [3:0] taken
);
    logic [3:0] ready_q;
    assign unit_ready = ~stall;
    always_ff @(posedge clock) ready_q <= unit_ready;
    // A pulse to a unit that was not ready is dropped, as real hardware would
    assign taken = unit_valid & ready_q;
endmodule // dic_unit_model
`default_nettype wire
